// [rtl/loop_path_pkg.sv]
/*
 * Shared constants and carriers for the per-channel loop-back path selector.
 * Assumes a single 20 MHz system clock domain; link clocks are sampled inputs.
 */
package loop_path_pkg;

	// ------------------------------------------------------------
	// Mode selector encodings
	// ------------------------------------------------------------
	localparam logic [1:0] PIN_NONE    = 2'h0;
	localparam logic [1:0] PIN_ANALOG  = 2'h1;
	localparam logic [1:0] PIN_REMOTE  = 2'h2;
	localparam logic [1:0] PIN_DIGITAL = 2'h3;
	localparam logic [2:0] HOST_DUAL    = 3'h4;
	localparam logic [2:0] HOST_ANALOG  = 3'h5;
	localparam logic [2:0] HOST_REMOTE  = 3'h6;
	localparam logic [2:0] HOST_DIGITAL = 3'h7;

	// ------------------------------------------------------------
	// Reset values, buffer size and synchroniser depth
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_RESET  = 3'h0;
	localparam int         BUF_DEPTH   = 2;
	localparam int         SYNC_STAGES = 2;

	// Resolved loop-back mode.
	typedef enum logic [2:0] {
		MODE_NONE    = 3'b000,
		MODE_ANALOG  = 3'b001,
		MODE_REMOTE  = 3'b010,
		MODE_DIGITAL = 3'b011,
		MODE_DUAL    = 3'b100
	} loop_mode_e;

	// One dual-rail symbol on a path.
	typedef struct packed {
		logic pos;
		logic neg;
	} sym_s;

endpackage

// [rtl/loop_path_select.sv]
/*
 * Per-channel loop-back path selector: routes transmit, receive, line driver
 * and line receiver symbols through an attenuator stand-in (two-entry buffer).
 * Assumes clocks and data from framer and line are asynchronous to clock,
 * whose 20 MHz rate is well above the 400 ns link clock period.
 */
// How it works
// - In analog mode the line driver output is fed into the receiver input.
// - In analog mode line receive pins are ignored while transmit data still goes out.
// - In analog mode the attenuator stays in the path that its select names.
// - In remote mode with receive-side attenuator, buffered receive data is transmitted on the recovered clock.
// - In remote mode system transmit clock and data are ignored while receive outputs continue.
// - In remote mode with transmit-side attenuator, recovered data passes the attenuator into the transmitter.
// - In digital mode system transmit clock and data return to the receive outputs, via the attenuator only when it is in the receive path.
// - In digital mode line receive data is ignored while transmit data still goes to the line.
// - In dual mode recovered line data goes back out to the line bypassing the attenuator.
// - In dual mode system transmit data goes through the attenuator to the receive outputs.
// - In dual mode the attenuator path select has no effect.
// - In pin control a two-bit selector gives none, analog, remote or digital.
// - In host control a three-bit field gives none when its top bit is low, else dual, analog, remote, digital.
module loop_path_select
	import loop_path_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// Mode control
	input  wire logic       host_mode,
	input  wire logic [1:0] pin_loop_sel,
	input  wire logic [2:0] host_loop_sel,
	input  wire logic       atten_enable,
	input  wire logic       atten_in_rx,
	// System transmit side
	input  wire logic       tx_clock_in,
	input  wire sym_s       tx_data_in,
	// Line receiver (after clock and data recovery)
	input  wire logic       rx_line_pos_in,
	input  wire logic       rx_line_neg_in,
	input  wire logic       rx_line_clock_in,
	// Line driver
	output logic            tx_line_pos_out,
	output logic            tx_line_neg_out,
	// System receive side
	output logic            rx_positive_data_out,
	output logic            rx_negative_data_out,
	output logic            rx_clock_out,
	// Attenuator buffer status
	output logic            atten_overflow
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic       tclk_prev;
	logic       rclk_prev;

	// Every link clock and data input passes two flops before any logic looks at it; mode and attenuator controls do not.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
		end else begin
			sync1 <= {tx_clock_in, tx_data_in, rx_line_clock_in, rx_line_pos_in, rx_line_neg_in};
			sync2 <= sync1;
		end
	end

	// Edge history for the two sampled link clocks.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tclk_prev <= 1'b0;
			rclk_prev <= 1'b0;
		end else begin
			tclk_prev <= sync2[5];
			rclk_prev <= sync2[2];
		end
	end

	logic tx_rise;
	logic rx_rise;
	sym_s tx_sym;
	sym_s line_sym;
	assign tx_rise  = sync2[5] & ~tclk_prev;
	assign rx_rise  = sync2[2] & ~rclk_prev;
	assign tx_sym   = sym_s'(sync2[4:3]);
	assign line_sym = sym_s'(sync2[1:0]);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	loop_mode_e mode;
	loop_mode_e next_mode;

	// Pin and host encodings differ only in the dual code.
	always_comb begin
		next_mode = MODE_NONE;
		if (host_mode) begin
			if (host_loop_sel[2]) begin
				unique case (host_loop_sel)
					HOST_DUAL:    next_mode = MODE_DUAL;
					HOST_ANALOG:  next_mode = MODE_ANALOG;
					HOST_REMOTE:  next_mode = MODE_REMOTE;
					HOST_DIGITAL: next_mode = MODE_DIGITAL;
					default:      next_mode = MODE_NONE;
				endcase
			end
		end else begin
			unique case (pin_loop_sel)
				PIN_NONE:    next_mode = MODE_NONE;
				PIN_ANALOG:  next_mode = MODE_ANALOG;
				PIN_REMOTE:  next_mode = MODE_REMOTE;
				PIN_DIGITAL: next_mode = MODE_DIGITAL;
			endcase
		end
	end

	// Registered so that a change of mode takes effect on a clean edge.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode <= loop_mode_e'(MODE_RESET);
		end else begin
			mode <= next_mode;
		end
	end

	// ------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------
	sym_s tx_src;       // Symbol heading toward the line.
	logic tx_src_rise;
	sym_s rx_src;       // Symbol heading toward the receiver outputs.
	logic rx_src_rise;
	logic att_on_tx;    // Attenuator sits in the toward-line path.
	logic att_on_rx;    // Attenuator sits in the toward-framer path.
	sym_s drv_now;      // Last symbol driven to the line.

	always_comb begin
		tx_src      = tx_sym;
		tx_src_rise = tx_rise;
		rx_src      = line_sym;
		rx_src_rise = rx_rise;
		att_on_tx   = atten_enable & ~atten_in_rx;
		att_on_rx   = atten_enable & atten_in_rx;
		unique case (mode)
			MODE_ANALOG: begin
				// driver output returned to receiver; line pins ignored
				rx_src      = drv_now;
				rx_src_rise = tx_rise;
				// attenuator stays where its select puts it
			end
			MODE_REMOTE: begin
				// system transmit ignored; recovered clock times the line
				tx_src      = line_sym;
				tx_src_rise = rx_rise;
			end
			MODE_DIGITAL: begin
				// transmit returns to receive outputs; line input ignored
				rx_src      = tx_sym;
				rx_src_rise = tx_rise;
			end
			MODE_DUAL: begin
				// line loops out unbuffered, transmit loops in buffered
				tx_src      = line_sym;
				tx_src_rise = rx_rise;
				rx_src      = tx_sym;
				rx_src_rise = tx_rise;
				att_on_tx   = 1'b0;
				att_on_rx   = atten_enable;
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------
	// Attenuator stand-in: two-entry buffer on one path
	// ------------------------------------------------------------
	// The buffer fills on the source clock and drains on the same rise one
	// symbol later, absorbing a one-word stall without loss.
	logic att_in_tx;
	sym_s buf_in;
	logic buf_in_valid;
	logic buf_in_ready;
	sym_s buf_out;
	logic buf_out_valid;
	logic buf_out_ready;
	sym_s buf_mem [BUF_DEPTH];
	logic         wr_ptr;
	logic         rd_ptr;
	logic [1:0]   count;

	assign att_in_tx     = att_on_tx;
	assign buf_in        = att_in_tx ? tx_src : rx_src;
	assign buf_in_valid  = (att_on_tx & tx_src_rise) | (att_on_rx & rx_src_rise);
	assign buf_in_ready  = (count != 2'(BUF_DEPTH));
	assign buf_out_valid = (count != 2'h0);
	assign buf_out_ready = buf_in_valid;
	assign buf_out       = buf_mem[rd_ptr];

	// Buffer storage and pointers; attenuator off flushes it.
	always_ff @(posedge clock) begin
		if (sys_rst || !atten_enable) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (buf_in_valid && buf_in_ready) begin
				buf_mem[wr_ptr] <= buf_in;
				wr_ptr          <= ~wr_ptr;
			end
			if (buf_out_valid && buf_out_ready) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + 2'(buf_in_valid && buf_in_ready)
			               - 2'(buf_out_valid && buf_out_ready);
		end
	end

	// Refused writes are sticky so a lost symbol is visible.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			atten_overflow <= 1'b0;
		end else if (buf_in_valid && !buf_in_ready) begin
			atten_overflow <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Line driver: the buffered symbol when the attenuator faces the line.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			drv_now <= '0;
		end else if (tx_src_rise) begin
			// remote loop sends the receive symbol taken after the attenuator
			drv_now <= ((att_on_tx || (mode == MODE_REMOTE && att_on_rx)) && buf_out_valid) ?
				buf_out : tx_src;
		end
	end
	assign tx_line_pos_out = drv_now.pos;
	assign tx_line_neg_out = drv_now.neg;

	// Receive outputs and clock follow the chosen receive source.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rx_positive_data_out <= 1'b0;
			rx_negative_data_out <= 1'b0;
			rx_clock_out         <= 1'b0;
		end else begin
			rx_clock_out <= rx_src_rise ? 1'b1 : (rx_clock_out & ~(mode == MODE_ANALOG ?
				~sync2[5] : (mode == MODE_DIGITAL || mode == MODE_DUAL) ? ~sync2[5] : ~sync2[2]));
			if (rx_src_rise) begin
				rx_positive_data_out <= (att_on_rx && buf_out_valid) ? buf_out.pos : rx_src.pos;
				rx_negative_data_out <= (att_on_rx && buf_out_valid) ? buf_out.neg : rx_src.neg;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_remote_ignores_tx: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_REMOTE) |-> (tx_src == line_sym))
		else $error("remote mode used system transmit data");
	chk_analog_rx_source: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_ANALOG) |-> (rx_src == drv_now))
		else $error("analog mode receiver not fed from driver");
	chk_digital_rx_source: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_DIGITAL) |-> (rx_src == tx_sym && rx_src_rise == tx_rise))
		else $error("digital mode receive not from transmit");
	chk_dual_bypass: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_DUAL) |-> (!att_on_tx && tx_src == line_sym))
		else $error("dual mode line path used attenuator");
	chk_dual_rx_path: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_DUAL) |-> (rx_src == tx_sym && att_on_rx == atten_enable))
		else $error("dual mode receive path wrong");
	chk_host_none: assert property (@(posedge clock) disable iff (sys_rst)
		(host_mode && !host_loop_sel[2]) |=> (mode == MODE_NONE))
		else $error("host top bit low did not give none");
	chk_pin_decode: assert property (@(posedge clock) disable iff (sys_rst)
		(!host_mode && pin_loop_sel == PIN_REMOTE) |=> (mode == MODE_REMOTE))
		else $error("pin remote code not decoded");
	chk_normal_path: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_NONE) |-> (tx_src == tx_sym && rx_src == line_sym))
		else $error("normal mode paths wrong");
	chk_remote_rx_atten: assert property (@(posedge clock) disable iff (sys_rst)
		(mode == MODE_REMOTE && att_on_rx && rx_rise && buf_out_valid) |=>
		(drv_now == $past(buf_out)))
		else $error("remote mode line not fed after attenuator");

endmodule

// [bench/framer_model.sv]
/*
 * Behavioural framer that drives the system transmit clock and symbol.
 * Assumes the bench starts it with run; the clock stands still otherwise.
 */
module framer_model
	import loop_path_pkg::*;
(
	// Clock and control
	input  wire logic clock,
	input  wire logic run,
	// Transmit pins
	output logic      tx_clock_in,
	output sym_s      tx_data_in,
	// Symbols sent at the last two rises
	output sym_s      last_sym,
	output sym_s      prev_sym
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] phase;

	// Data moves on the falling edge so it is stable around each rise.
	// The link clock toggles every four system clocks, a 400 ns period.
	// It stands still while run is low, so no symbol is sent before start.
	initial begin
		tx_clock_in = 1'b0;
		tx_data_in  = '0;
		last_sym    = '0;
		prev_sym    = '0;
		phase       = 2'h0;
		forever begin
			@(posedge clock);
			if (run) begin
				phase <= phase + 2'h1;
				if (phase == 2'h3) begin
					tx_clock_in <= ~tx_clock_in;
					if (!tx_clock_in) begin
						prev_sym <= last_sym;
						last_sym <= tx_data_in;
					end else begin
						tx_data_in <= 2'($urandom);
					end
				end
			end
		end
	end
endmodule

// [bench/loop_path_select_tb.sv]
/*
 * Self-checking bench for the loop-back path selector.
 * Assumes the framer model and the line side share one 400 ns link clock.
 */
module loop_path_select_tb
	import loop_path_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clock, sys_rst, host_mode, atten_enable, atten_in_rx, run;
	logic [1:0] pin_loop_sel;
	logic [2:0] host_loop_sel;
	logic       tx_clock_in, tx_line_pos_out, tx_line_neg_out, rx_clock_out;
	logic       rx_positive_data_out, rx_negative_data_out, atten_overflow;
	sym_s       tx_data_in, t_cur, t_prev, r_nxt, r_cur, r_prev;
	int         n_fail, cmp_count;

	framer_model u_framer (.clock(clock), .run(run), .tx_clock_in(tx_clock_in),
		.tx_data_in(tx_data_in),
		.last_sym(t_cur), .prev_sym(t_prev));

	loop_path_select u_dut (.clock(clock), .sys_rst(sys_rst), .host_mode(host_mode),
		.pin_loop_sel(pin_loop_sel), .host_loop_sel(host_loop_sel),
		.atten_enable(atten_enable), .atten_in_rx(atten_in_rx),
		.tx_clock_in(tx_clock_in), .tx_data_in(tx_data_in),
		.rx_line_pos_in(r_nxt.pos), .rx_line_neg_in(r_nxt.neg),
		.rx_line_clock_in(tx_clock_in), .tx_line_pos_out(tx_line_pos_out),
		.tx_line_neg_out(tx_line_neg_out), .rx_positive_data_out(rx_positive_data_out),
		.rx_negative_data_out(rx_negative_data_out), .rx_clock_out(rx_clock_out),
		.atten_overflow(atten_overflow));

	// --------------------------------------------------------
	// Clock and line side
	// --------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// The line changes its symbol away from the recovered clock rise.
	always @(negedge tx_clock_in) r_nxt <= 2'($urandom);
	always @(posedge tx_clock_in) begin
		r_prev <= r_cur;
		r_cur  <= r_nxt;
	end

	// --------------------------------------------------------
	// Helpers
	// --------------------------------------------------------
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Bounded wait for a link clock rise; a stuck clock ends the run.
	task automatic wait_rise();
		logic old;
		old = tx_clock_in;
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			if (tx_clock_in && !old)
				return;
			old = tx_clock_in;
		end
		n_fail++;
		test_done();
	endtask

	function automatic loop_mode_e mode_of(logic hm, logic [1:0] p, logic [2:0] h);
		if (!hm)
			return loop_mode_e'({1'b0, p});
		if (!h[2])
			return MODE_NONE;
		return (h[1:0] == 2'h0) ? MODE_DUAL : loop_mode_e'({1'b0, h[1:0]});
	endfunction

	// Applies a mode, lets the path settle, then checks several symbols.
	task automatic run_mode(logic hm, logic [1:0] p, logic [2:0] h, logic aen, logic arx);
		sym_s l, r;
		logic lo, hi;
		@(posedge clock);
		host_mode     <= hm;
		pin_loop_sel  <= p;
		host_loop_sel <= h;
		atten_enable  <= aen;
		atten_in_rx   <= arx;
		for (int k = 0; k < 7; k++) begin
			wait_rise();
			lo = rx_clock_out;
			repeat (4) @(posedge clock);
			hi = rx_clock_out;
			repeat (2) @(posedge clock);
			l = t_cur;
			r = r_cur;
			case (mode_of(hm, p, h))
				MODE_NONE: begin
					if (aen && !arx) l = t_prev;
					if (aen && arx) r = r_prev;
				end
				MODE_ANALOG: r = t_prev;
				MODE_REMOTE: begin
					l = aen ? r_prev : r_cur;
					if (aen && arx) r = r_prev;
				end
				MODE_DIGITAL: begin
					r = (aen && arx) ? t_prev : t_cur;
					if (aen && !arx) l = t_prev;
				end
				default: begin
					l = r_cur;
					r = aen ? t_prev : t_cur;
				end
			endcase
			if (k >= 3) begin
				check({tx_line_pos_out, tx_line_neg_out, rx_positive_data_out,
					rx_negative_data_out}, {l, r});
				check({2'h0, hi, lo}, 4'h2);
			end
		end
	endtask

	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		n_fail = 0;
		cmp_count = 0;
		void'($urandom(45));
		{sys_rst, host_mode, atten_enable, atten_in_rx, run} = 5'h10;
		pin_loop_sel  = 2'h0;
		host_loop_sel = 3'h0;
		repeat (16) @(posedge clock);
		check({tx_line_pos_out, tx_line_neg_out, rx_positive_data_out,
			rx_negative_data_out}, 4'h0);
		check({3'h0, rx_clock_out}, 4'h0);
		sys_rst <= 1'b0;
		run     <= 1'b1;
		// Every pin code, then every host code, with the attenuator out.
		for (int p = 0; p < 4; p++)
			run_mode(1'b0, 2'(p), 3'(7 - p), 1'b0, 1'b0);
		for (int h = 0; h < 8; h++)
			run_mode(1'b1, 2'(3 - (h % 4)), 3'(h), 1'b0, 1'b0);
		// Attenuator in each path for none, remote, dual and digital.
		for (int s = 0; s < 8; s++)
			run_mode(1'b1, 2'h0, (s < 2) ? 3'h0 : ((s < 4) ? 3'h6 : ((s < 6) ? 3'h4 : 3'h7)),
				1'b1, s[0]);
		check({3'h0, atten_overflow}, 4'h0);
		test_done();
	end
endmodule
